// ---- hdl/usf_pkg.sv ----
// package: constants and types of the serial status-flag block
// assumes: one core clock, byte-addressed avalon-mm slave, 32-bit data
package usf_pkg;

    // --------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------
    localparam int unsigned ADDR_W     = 5;
    localparam logic [4:0]  OFS_DATA   = 5'h00;
    localparam logic [4:0]  OFS_STATUS = 5'h04;
    localparam logic [4:0]  OFS_CTRL   = 5'h08;
    localparam logic [4:0]  OFS_EVT    = 5'h0c;
    localparam logic [4:0]  OFS_MASK   = 5'h10;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int unsigned ST_TX_EMPTY = 7;
    localparam int unsigned ST_TX_DONE  = 6;
    localparam int unsigned ST_RX_FULL  = 5;
    localparam int unsigned ST_QUIET    = 4;
    localparam int unsigned CT_QSEL     = 6;
    localparam int unsigned CT_RX_IE    = 5;
    localparam int unsigned CT_QUIET_IE = 4;
    localparam int unsigned CT_TX_ON    = 3;
    localparam int unsigned CT_BREAK    = 0;
    localparam int unsigned EV_RX       = 0;
    localparam int unsigned EV_QUIET    = 1;
    localparam int unsigned EV_TX_DONE  = 2;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] EVT_RST  = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    // --------------------------------------------------------------
    // timing counts
    // --------------------------------------------------------------
    localparam int unsigned BIT_CYCLES    = 16;
    localparam int unsigned FRAME_BITS    = 10;
    localparam int unsigned QUIET_BITS    = 10;
    localparam int unsigned QUIET_CYCLES  = QUIET_BITS * BIT_CYCLES;
    localparam int unsigned TIMER_W       = 8;
    localparam logic [7:0]  BIT_LAST      = 8'(BIT_CYCLES - 1);
    localparam logic [7:0]  BIT_HALF      = 8'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0]  FRAME_LAST    = 4'(FRAME_BITS - 1);
    localparam logic [2:0]  DATA_LAST     = 3'h7;
    localparam logic [8:0]  QUIET_LAST    = 9'(QUIET_CYCLES - 1);

    // --------------------------------------------------------------
    // state types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {RX_WAIT, RX_START, RX_DATA, RX_STOP} usf_rx_state_type;
    typedef enum logic       {TX_IDLE, TX_SHIFT} usf_tx_state_type;

endpackage

// ---- hdl/usf_rx_if.sv ----
// interface: receive monitor to flag core
// assumes: both ends run on the same core clock
`timescale 1ns/10ps
interface usf_rx_if;
    logic       quiet_start_select;
    logic       char_done;
    logic [7:0] char_data;
    logic       quiet_hit;

    modport mon  (input quiet_start_select, output char_done, char_data, quiet_hit);
    modport core (output quiet_start_select, input char_done, char_data, quiet_hit);
endinterface

// ---- hdl/usf_rx_monitor.sv ----
// receive line monitor: character framing and quiet-line timing
// assumes: 8n1 frames at BIT_CYCLES core clocks per bit, line idles high
`timescale 1ns/10ps
module usf_rx_monitor
    import usf_pkg::*;
(
    // clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_sys_rst,
    // serial line
    input  wire logic  i_rx_pin,
    // flag core
    usf_rx_if.mon      rx
);

    logic             rx_meta;
    logic             rx_line;
    usf_rx_state_type state;
    usf_rx_state_type next_state;
    logic [7:0]       timer;
    logic [2:0]       bit_idx;
    logic [7:0]       shift;
    logic [8:0]       quiet_cnt;
    logic             mid_bit;
    logic             quiet_clear;

    // --------------------------------------------------------------
    // line synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_meta <= 1'b1;
            rx_line <= 1'b1;
        end else begin
            rx_meta <= i_rx_pin;
            rx_line <= rx_meta;
        end
    end

    // --------------------------------------------------------------
    // framing
    // --------------------------------------------------------------
    assign mid_bit = (state == RX_START) ? (timer == BIT_HALF) : (timer == BIT_LAST);

    always_comb begin
        next_state = state;
        case (state)
            RX_WAIT:  if (!rx_line) next_state = RX_START;
            RX_START: if (mid_bit) next_state = rx_line ? RX_WAIT : RX_DATA;
            RX_DATA:  if (mid_bit && bit_idx == DATA_LAST) next_state = RX_STOP;
            RX_STOP:  if (mid_bit) next_state = RX_WAIT;
            default:  next_state = RX_WAIT;
        endcase
    end

    // timer restarts on every sampled bit; data shifts in lsb first
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state        <= RX_WAIT;
            timer        <= 8'h00;
            bit_idx      <= 3'h0;
            shift        <= 8'h00;
            rx.char_done <= 1'b0;
            rx.char_data <= 8'h00;
        end else begin
            state        <= next_state;
            timer        <= (state == RX_WAIT || mid_bit) ? 8'h00 : timer + 8'h01;
            rx.char_done <= (state == RX_STOP) && mid_bit;
            if (state == RX_DATA && mid_bit) begin
                shift   <= {rx_line, shift[7:1]};
                bit_idx <= bit_idx + 3'h1;
            end
            if (state == RX_START) begin
                bit_idx <= 3'h0;
            end
            if (state == RX_STOP && mid_bit) begin
                rx.char_data <= shift;
            end
        end
    end

    // --------------------------------------------------------------
    // quiet-line counter
    // --------------------------------------------------------------
    // select clear: high time counts from after the start bit, so an
    // all-ones character already counts; select set: counting starts at the mid-bit sample of the stop bit
    assign quiet_clear = !rx_line || state == RX_START
                         || (rx.quiet_start_select && state != RX_WAIT);

    // counter saturates, so the hit fires once per quiet stretch
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quiet_cnt    <= 9'h000;
            rx.quiet_hit <= 1'b0;
        end else begin
            rx.quiet_hit <= !quiet_clear && quiet_cnt == QUIET_LAST;
            if (quiet_clear) begin
                quiet_cnt <= 9'h000;
            end else if (quiet_cnt <= QUIET_LAST) begin
                quiet_cnt <= quiet_cnt + 9'h001;
            end
        end
    end

endmodule

// ---- hdl/usf_uart_status.sv ----
// serial transceiver status flags with avalon-mm register slave
// assumes: single core clock, software on the bus, remote peer on the lines
//
// Operation
// - transmit-empty flag in bit 7, set from reset and when buffer can take a byte.
// - data register write clears transmit-empty flag.
// - transmit-complete flag in bit 6 set at reset and when all shifting ends.
// - data write, transmitter turn-on or break request clears transmit-complete.
// - transmit-complete reads 0 during data, preamble or break, 1 when done.
// - receive-full flag in bit 5 set while a received character waits.
// - data register read clears receive-full flag.
// - quiet flag in bit 4 set after a full character time of high line.
// - select clear: quiet counting starts after the start bit.
// - select set: quiet counting starts only after the stop bit; here it starts once the stop bit is sampled at mid-bit.
// - writing 1 to quiet bit clears it; writing 0 leaves it.
// - quiet flag rearms only after a new character sets receive-full.
// - quiet flag sets once per quiet stretch, however long.
// - receive interrupt enable requests interrupt while receive-full is 1.
// - quiet interrupt enable requests interrupt while quiet flag is 1.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module usf_uart_status
    import usf_pkg::*;
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // serial lines
    input  wire logic              i_rx_pin,
    output logic                   o_tx_pin,
    output logic                   o_tx_oe,
    // interrupt
    output logic                   o_irq
);

    usf_rx_if rx ();

    logic             ack;
    logic             req;
    logic             wr_acc;
    logic             rd_acc;
    logic             wr_data;
    logic             rd_data;
    logic             wr_status;
    logic             wr_ctrl;
    logic             wr_evt;
    logic             wr_mask;
    logic [31:0]      rd_mux;
    logic [7:0]       ctrl;
    logic [2:0]       evt;
    logic [2:0]       mask;
    logic [7:0]       status;
    logic [7:0]       tx_buf;
    logic             tx_empty;
    logic             tx_done;
    logic             tx_on_q;
    logic             tx_on_rise;
    logic             break_write;
    logic             pend_pre;
    logic             pend_brk;
    usf_tx_state_type tx_state;
    logic [9:0]       tx_shift;
    logic [3:0]       tx_bits;
    logic [7:0]       tx_timer;
    logic             tx_load;
    logic             tx_bit_end;
    logic             tx_last;
    logic             tx_done_set;
    logic             tx_done_clr;
    logic [7:0]       rx_buf;
    logic             rx_full;
    logic             quiet;
    logic             quiet_armed;
    logic             quiet_set;
    logic             quiet_clr;
    logic [2:0]       evt_hit;

    // decodes one register address
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    // one wait cycle per access: the read mux is registered in the wait
    // cycle, so read data stand at the edge where waitrequest drops
    assign req               = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = req && !ack;
    assign wr_acc            = i_avs_write && ack;
    assign rd_acc            = i_avs_read && ack;
    assign wr_data           = wr_acc && hit(i_avs_address, OFS_DATA);
    assign rd_data           = rd_acc && hit(i_avs_address, OFS_DATA);
    assign wr_status         = wr_acc && hit(i_avs_address, OFS_STATUS);
    assign wr_ctrl           = wr_acc && hit(i_avs_address, OFS_CTRL);
    assign wr_evt            = wr_acc && hit(i_avs_address, OFS_EVT);
    assign wr_mask           = wr_acc && hit(i_avs_address, OFS_MASK);

    // status word; reading it has no side effect
    assign status = {tx_empty, tx_done, rx_full, quiet, 4'h0};

    // read mux; unmapped addresses read zero
    assign rd_mux = hit(i_avs_address, OFS_DATA)   ? {24'h000000, rx_buf} :
                    hit(i_avs_address, OFS_STATUS) ? {24'h000000, status} :
                    hit(i_avs_address, OFS_CTRL)   ? {24'h000000, ctrl}   :
                    hit(i_avs_address, OFS_EVT)    ? {29'h0, evt}         :
                    hit(i_avs_address, OFS_MASK)   ? {29'h0, mask}        :
                    32'h00000000;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack            <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            ack <= req && !ack;
            if (i_avs_read && !ack) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    // --------------------------------------------------------------
    // control, event and mask registers
    // --------------------------------------------------------------
    assign tx_on_rise  = wr_ctrl && i_avs_writedata[CT_TX_ON] && !ctrl[CT_TX_ON];
    assign break_write = wr_ctrl && i_avs_writedata[CT_BREAK];
    assign evt_hit     = {tx_done_set && !tx_done, quiet_set, rx.char_done};

    // event bits: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl <= CTRL_RST;
            evt  <= EVT_RST;
            mask <= MASK_RST;
        end else begin
            if (wr_ctrl) ctrl <= i_avs_writedata[7:0];
            if (wr_mask) mask <= i_avs_writedata[2:0];
            evt <= (evt & ~(wr_evt ? i_avs_writedata[2:0] : 3'h0)) | evt_hit;
        end
    end

    assign rx.quiet_start_select = ctrl[CT_QSEL];

    // level interrupt: enabled flags plus unmasked sticky events
    assign o_irq = (rx_full && ctrl[CT_RX_IE])
                   || (quiet && ctrl[CT_QUIET_IE])
                   || (|(evt & mask));

    // --------------------------------------------------------------
    // transmit buffer and empty flag
    // --------------------------------------------------------------
    // the shifter takes the buffer only in a cycle without a data write,
    // so a load never collides with a refill
    assign tx_load = tx_state == TX_IDLE && !tx_empty && !wr_data && !pend_pre && !pend_brk;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_buf   <= 8'h00;
            tx_empty <= 1'b1;
        end else begin
            if (wr_data) begin
                tx_buf   <= i_avs_writedata[7:0];
                tx_empty <= 1'b0;
            end else if (tx_load) begin
                tx_empty <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // preamble and break queue
    // --------------------------------------------------------------
    // a queued preamble or break goes out before any waiting data byte
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_on_q  <= 1'b0;
            pend_pre <= 1'b0;
            pend_brk <= 1'b0;
        end else begin
            tx_on_q <= ctrl[CT_TX_ON];
            if (ctrl[CT_TX_ON] && !tx_on_q) begin
                pend_pre <= 1'b1;
            end else if (tx_state == TX_IDLE && !pend_brk) begin
                pend_pre <= 1'b0;
            end
            if (break_write) begin
                pend_brk <= 1'b1;
            end else if (tx_state == TX_IDLE) begin
                pend_brk <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // transmit shifter
    // --------------------------------------------------------------
    assign tx_bit_end = tx_timer == BIT_LAST;
    assign tx_last    = tx_bit_end && tx_bits == FRAME_LAST;

    // frames go lsb first: start, eight data bits, stop
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_state <= TX_IDLE;
            tx_shift <= 10'h3ff;
            tx_bits  <= 4'h0;
            tx_timer <= 8'h00;
            o_tx_pin <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_bits  <= 4'h0;
                    tx_timer <= 8'h00;
                    o_tx_pin <= 1'b1;
                    if (pend_brk) begin
                        tx_shift <= 10'h000;
                        tx_state <= TX_SHIFT;
                    end else if (pend_pre) begin
                        tx_shift <= 10'h3ff;
                        tx_state <= TX_SHIFT;
                    end else if (tx_load) begin
                        tx_shift <= {1'b1, tx_buf, 1'b0};
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    o_tx_pin <= tx_shift[0];
                    tx_timer <= tx_bit_end ? 8'h00 : tx_timer + 8'h01;
                    if (tx_bit_end) begin
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        tx_bits  <= tx_bits + 4'h1;
                    end
                    if (tx_last) tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // pin is driven while enabled, while shifting, and until a low last bit
    // has left the pin flop, so a break never ends on a released line
    assign o_tx_oe = ctrl[CT_TX_ON] || tx_state == TX_SHIFT || !o_tx_pin;

    // --------------------------------------------------------------
    // transmission complete
    // --------------------------------------------------------------
    // clear sources start new activity, so they win over the set term
    assign tx_done_clr = wr_data || tx_on_rise || break_write;
    // a turn-on still in the edge detector holds the set off one more cycle
    assign tx_done_set = tx_empty && tx_state == TX_IDLE && !pend_pre && !tx_load
                         && !pend_brk && !(ctrl[CT_TX_ON] && !tx_on_q);

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_done <= 1'b1;
        end else if (tx_done_clr) begin
            tx_done <= 1'b0;
        end else begin
            tx_done <= tx_done_set;
        end
    end

    // --------------------------------------------------------------
    // receive buffer and full flag
    // --------------------------------------------------------------
    // a new character wins over a data read in the same cycle
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_buf  <= 8'h00;
            rx_full <= 1'b0;
        end else begin
            if (rx.char_done) begin
                rx_buf  <= rx.char_data;
                rx_full <= 1'b1;
            end else if (rd_data) begin
                rx_full <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // quiet-line flag
    // --------------------------------------------------------------
    assign quiet_set = rx.quiet_hit && quiet_armed;
    assign quiet_clr = wr_status && i_avs_writedata[ST_QUIET];

    // arming happens with each received character and is used up by a set
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quiet       <= 1'b0;
            quiet_armed <= 1'b0;
        end else begin
            if (rx.char_done) begin
                quiet_armed <= 1'b1;
            end else if (quiet_set) begin
                quiet_armed <= 1'b0;
            end
            if (quiet_set) begin
                quiet <= 1'b1;
            end else if (quiet_clr) begin
                quiet <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // receive monitor
    // --------------------------------------------------------------
    usf_rx_monitor u_rx_monitor (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_rx_pin   (i_rx_pin),
        .rx         (rx.mon)
    );

endmodule

// ---- testbench/usf_uart_status_assertions.sv ----
// checker: bus timing, line levels and interrupt ties of the status block
// assumes: bound to usf_uart_status, one clock domain
`timescale 1ns/10ps
module usf_status_checker
    import usf_pkg::*;
(
    // clock and reset
    input wire logic              i_core_clk,
    input wire logic              i_sys_rst,
    // bus and lines
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       i_avs_writedata,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic              i_rx_pin,
    input wire logic              o_tx_pin,
    input wire logic              o_tx_oe,
    input wire logic              o_irq
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    logic       req;
    logic       rd_ok;
    logic       wr_ok;
    logic [7:0] ctrl_q;
    assign req   = i_avs_read | i_avs_write;
    assign rd_ok = i_avs_read & ~o_avs_waitrequest;
    assign wr_ok = i_avs_write & ~o_avs_waitrequest;
    // shadow of control, so irq and line checks know the enables
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
        if (i_sys_rst) ctrl_q <= CTRL_RST;
        else if (wr_ok && i_avs_address == OFS_CTRL) ctrl_q <= i_avs_writedata[7:0];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("request not held in first cycle");
    a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("wait longer than one cycle");
    a_unmapped_zero: assert property (rd_ok && i_avs_address > OFS_MASK |-> o_avs_readdata == 0)
        else $error("unmapped read not zero");
    a_status_pad: assert property (rd_ok && i_avs_address == OFS_STATUS
        |-> o_avs_readdata[31:8] == 0 && o_avs_readdata[3:0] == 0)
        else $error("status spare bits set");
    a_tx_idle_high: assert property (!o_tx_oe |-> o_tx_pin)
        else $error("tx line low while undriven");
    a_rx_irq: assert property (rd_ok && i_avs_address == OFS_STATUS && o_avs_readdata[5]
        && ctrl_q[5] |-> o_irq) else $error("rx irq missing");
    a_quiet_irq: assert property (rd_ok && i_avs_address == OFS_STATUS && o_avs_readdata[4]
        && ctrl_q[4] |-> o_irq) else $error("quiet irq missing");
    a_break_low: assert property (wr_ok && i_avs_address == OFS_CTRL && i_avs_writedata[0]
        |-> ##[1:200] !o_tx_pin) else $error("break not sent");
    a_data_low: assert property (wr_ok && i_avs_address == OFS_DATA && ctrl_q[3]
        |-> ##[1:400] !o_tx_pin) else $error("data not sent");
endmodule
bind usf_uart_status usf_status_checker u_chk (.i_core_clk, .i_sys_rst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
    .i_rx_pin, .o_tx_pin, .o_tx_oe, .o_irq);

// ---- testbench/usf_peer_model.sv ----
// partner: remote serial sender on the receive line, 8n1, lsb first
// assumes: same core clock as the block, BIT_CYCLES clocks per bit
`timescale 1ns/10ps
module usf_peer_model
    import usf_pkg::*;
(
    // clock
    input  wire logic       i_core_clk,
    // frame request
    input  wire logic       i_send,
    input  wire logic [7:0] i_byte,
    // serial line
    output logic            o_line
);
    logic [9:0] shift = 10'h3ff;
    int         left  = 0;
    // one frame per request; line rests high (pulled up) between frames
    always @(posedge i_core_clk) begin
        if (i_send && left == 0) begin
            shift <= {1'b1, i_byte, 1'b0};
            left  <= FRAME_BITS * BIT_CYCLES;
        end else if (left != 0) begin
            left <= left - 1;
            if (left % BIT_CYCLES == 1) shift <= {1'b1, shift[9:1]};
        end
    end
    assign o_line = (left == 0) ? 1'b1 : shift[0];
endmodule

// ---- testbench/uart_status_flags_bench.sv ----
// bench: status flags over the register bus, peer on the receive line
// assumes: checker bound to the block, one 50 mhz clock
`timescale 1ns/10ps
module uart_status_flags_bench;
    import usf_pkg::*;
    logic              i_core_clk = 0;
    logic              i_sys_rst = 1;
    logic [ADDR_W-1:0] i_avs_address = '0;
    logic              i_avs_read = 0;
    logic              i_avs_write = 0;
    logic [31:0]       i_avs_writedata = '0;
    logic [31:0]       o_avs_readdata;
    logic              o_avs_waitrequest, o_tx_pin, o_tx_oe, o_irq, i_rx_pin;
    logic              send = 0;
    logic [7:0]        send_byte = '0;
    logic [63:0]       notes[$];
    logic [31:0]       seed = 32'h3;
    int                mismatches = 0, total_checks = 0, cycles = 0;
    usf_uart_status dut (.i_core_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_rx_pin, .o_tx_pin,
        .o_tx_oe, .o_irq);
    usf_peer_model peer (.i_core_clk, .i_send(send), .i_byte(send_byte), .o_line(i_rx_pin));
    initial forever #10 i_core_clk = ~i_core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_avs_write <= w;
        i_avs_read <= ~w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        @(posedge i_core_clk iff !o_avs_waitrequest);
        i_avs_write <= 0;
        i_avs_read <= 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({e, m});
        bus(0, a, 32'h0);
    endtask
    // watcher: each accepted read takes the oldest note
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
        else if (i_avs_read && !o_avs_waitrequest && notes.size() > 0) begin
            check(o_avs_readdata & notes[0][31:0], notes[0][63:32]);
            void'(notes.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_sys_rst <= 0;
        rd(OFS_STATUS, 32'hc0, 32'hffffffff);
        rd(5'h14, 32'h0, 32'hffffffff);
        $display("test reset done");
        bus(1, OFS_CTRL, 32'h08);
        rd(OFS_STATUS, 32'h00, 32'h40);
        seed = xs(seed);
        bus(1, OFS_DATA, {24'h0, seed[7:0]});
        rd(OFS_STATUS, 32'h00, 32'hc0);
        repeat (400) @(posedge i_core_clk);
        rd(OFS_STATUS, 32'hc0, 32'hc0);
        bus(1, OFS_CTRL, 32'h09);
        rd(OFS_STATUS, 32'h00, 32'h40);
        repeat (200) @(posedge i_core_clk);
        rd(OFS_STATUS, 32'hc0, 32'hc0);
        $display("test transmit done");
        // all-ones byte: start-bit counting ends well before stop-bit counting
        for (int s = 0; s < 2; s++) begin
            bus(1, OFS_CTRL, {25'h0, s[0], 6'h38});
            @(posedge i_core_clk);
            send <= 1;
            send_byte <= 8'hff;
            @(posedge i_core_clk);
            send <= 0;
            repeat (240) @(posedge i_core_clk);
            rd(OFS_STATUS, s ? 32'he0 : 32'hf0, 32'hf0);
            repeat (150) @(posedge i_core_clk);
            rd(OFS_STATUS, 32'hf0, 32'hf0);
            rd(OFS_DATA, 32'hff, 32'hff);
            bus(1, OFS_STATUS, 32'h0);
            rd(OFS_STATUS, 32'hd0, 32'hf0);
            rd(OFS_STATUS, 32'hd0, 32'hf0);
            @(negedge i_core_clk) check({31'h0, o_irq}, 32'h1);
            bus(1, OFS_STATUS, 32'h10);
            rd(OFS_STATUS, 32'hc0, 32'hf0);
            @(negedge i_core_clk) check({31'h0, o_irq}, 32'h0);
            repeat (400) @(posedge i_core_clk);
            rd(OFS_STATUS, 32'hc0, 32'hf0);
            $display("test quiet select %0d done", s);
        end
        rd(OFS_EVT, 32'h7, 32'h7);
        bus(1, OFS_EVT, 32'h7);
        rd(OFS_EVT, 32'h0, 32'h7);
        $display("test events done");
        print_verdict();
    end
endmodule
